// [src/acc_regs_top.sv]
// Channel calibration register bank with AHB-Lite slave port
`timescale 1ns/10ps
module acc_regs_top
  import acc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [3:0]  global_dc_filter_setting,
  input  wire logic        conv_start,
  input  wire logic        mod_tick,
  input  wire logic [23:0] ch1_sample,
  input  wire logic        ch1_sample_valid,
  output logic      [7:0]  ch1_offset_low_bits,
  output logic      [15:0] ch1_gain_high_bits,
  output logic      [7:0]  ch1_gain_low_bits,
  output logic      [23:0] ch1_gain,
  output logic      [23:0] ch1_corrected,
  output logic             ch1_corrected_valid,
  output logic      [9:0]  ch2_sample_delay,
  output logic             ch2_dc_filter_bypass,
  output logic             ch2_dc_filter_active,
  output logic      [1:0]  ch2_input_select,
  output logic             ch2_sel_pins,
  output logic             ch2_sel_short,
  output logic             ch2_sel_test_pos,
  output logic             ch2_sel_test_neg,
  output logic      [15:0] ch2_offset_high_bits,
  output logic      [7:0]  ch2_offset_low_bits,
  output logic      [23:0] ch2_offset,
  output logic      [15:0] ch2_gain_high_bits,
  output logic             ch2_convert
);

  // ************************************************************
  // Bus address phase
  // ************************************************************
  logic              addr_take;
  logic              addr_hit;
  logic [2:0]        addr_entry;
  logic              wr_pend_q;
  logic              wr_pend_d;
  logic [2:0]        wr_entry_q;
  logic [2:0]        wr_entry_d;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;
  logic [15:0]       rd_word;
  logic [15:0]       wr_word;
  logic [ACC_NREG-1:0][15:0] reg_q;
  logic [ACC_NREG-1:0][15:0] reg_d;

  // Only word transfers are used; hsize is not checked
  assign addr_take  = hsel && hready && (htrans == ACC_HTRANS_NONSEQ ||
                      htrans == ACC_HTRANS_SEQ);
  assign addr_hit   = (haddr[7:2] >= ACC_IDX_FIRST) && (haddr[7:2] <= ACC_IDX_LAST);
  assign addr_entry = 3'(haddr[7:2] - ACC_IDX_FIRST);
  assign wr_word    = hwdata[15:0];

  always_comb begin
    wr_pend_d  = 1'b0;
    wr_entry_d = wr_entry_q;
    if (addr_take && hwrite && addr_hit) begin
      wr_pend_d  = 1'b1;
      wr_entry_d = addr_entry;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q  <= 1'b0;
      wr_entry_q <= 3'h0;
    end else begin
      wr_pend_q  <= wr_pend_d;
      wr_entry_q <= wr_entry_d;
    end
  end

  // ************************************************************
  // Register storage
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < ACC_NREG; gi++) begin : g_reg
      always_comb begin
        reg_d[gi] = reg_q[gi];
        if (wr_pend_q && wr_entry_q == 3'(gi)) begin
          reg_d[gi] = wr_word & ACC_WR_MASK[gi];
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          reg_q[gi] <= ACC_RST_VAL[gi];
        end else begin
          reg_q[gi] <= reg_d[gi];
        end
      end
    end
  endgenerate

  // ************************************************************
  // Read data
  // ************************************************************
  always_comb begin
    rd_word = 16'h0000;
    if (addr_hit) begin
      rd_word = reg_q[addr_entry];
      // Back-to-back write then read: forward the word being written
      if (wr_pend_q && wr_entry_q == addr_entry) begin
        rd_word = wr_word & ACC_WR_MASK[addr_entry];
      end
    end
    rdata_d = 32'h0000_0000;
    if (addr_take && !hwrite) begin
      rdata_d = {16'h0000, rd_word};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ************************************************************
  // Field views
  // ************************************************************
  assign ch1_offset_low_bits  = reg_q[ACC_E_CH1_OCAL_LO][ACC_LO_FIELD_MSB:ACC_LO_FIELD_LSB];
  assign ch1_gain_high_bits   = reg_q[ACC_E_CH1_GCAL_HI];
  assign ch1_gain_low_bits    = reg_q[ACC_E_CH1_GCAL_LO][ACC_LO_FIELD_MSB:ACC_LO_FIELD_LSB];
  assign ch1_gain             = {ch1_gain_high_bits, ch1_gain_low_bits};
  assign ch2_offset_high_bits = reg_q[ACC_E_CH2_OCAL_HI];
  assign ch2_offset_low_bits  = reg_q[ACC_E_CH2_OCAL_LO][ACC_LO_FIELD_MSB:ACC_LO_FIELD_LSB];
  assign ch2_offset           = {ch2_offset_high_bits, ch2_offset_low_bits};
  assign ch2_gain_high_bits   = reg_q[ACC_E_CH2_GCAL_HI];
  assign ch2_sample_delay     = reg_q[ACC_E_CH2_SETUP][ACC_DLY_MSB:ACC_DLY_LSB];
  assign ch2_dc_filter_bypass = reg_q[ACC_E_CH2_SETUP][ACC_BYP_BIT];
  assign ch2_input_select     = reg_q[ACC_E_CH2_SETUP][ACC_SEL_MSB:ACC_SEL_LSB];

  // Global setting governs unless this channel opts out
  assign ch2_dc_filter_active = !ch2_dc_filter_bypass && (|global_dc_filter_setting);

  assign ch2_sel_pins     = (ch2_input_select == ACC_SEL_PINS);
  assign ch2_sel_short    = (ch2_input_select == ACC_SEL_SHORT);
  assign ch2_sel_test_pos = (ch2_input_select == ACC_SEL_TEST_POS);
  assign ch2_sel_test_neg = (ch2_input_select == ACC_SEL_TEST_NEG);

  // ************************************************************
  // Datapath helpers
  // ************************************************************
  acc_gain_apply u_gain (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .gain             (ch1_gain),
    .sample_in        (ch1_sample),
    .sample_in_valid  (ch1_sample_valid),
    .sample_out       (ch1_corrected),
    .sample_out_valid (ch1_corrected_valid)
  );

  acc_sample_delay u_delay (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .delay    (ch2_sample_delay),
    .start    (conv_start),
    .mod_tick (mod_tick),
    .convert  (ch2_convert)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_wr_data(logic [2:0] ent);
    wr_pend_q && wr_entry_q == ent;
  endsequence

  sequence s_rd_addr(logic [5:0] idx);
    addr_take && !hwrite && haddr[7:2] == idx;
  endsequence

  a_ofs_high_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    s_wr_data(ACC_E_CH2_OCAL_HI) |=> ch2_offset[23:8] == $past(hwdata[15:0]))
    else $error("offset high word not placed in bits 23:8");

  a_ofs_low_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    s_wr_data(ACC_E_CH2_OCAL_LO) |=> ch2_offset[7:0] == $past(hwdata[15:8]))
    else $error("offset low byte not placed in bits 7:0");

  a_gain_high_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    s_wr_data(ACC_E_CH1_GCAL_HI) |=> ch1_gain[23:8] == $past(hwdata[15:0]))
    else $error("gain high word not placed in bits 23:8");

  a_gain_low_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    s_wr_data(ACC_E_CH1_GCAL_LO) |=> ch1_gain[7:0] == $past(hwdata[15:8]))
    else $error("gain low byte not placed in bits 7:0");

  a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    s_rd_addr(ACC_IDX_CH2_SETUP) |=> hrdata[5:3] == 3'h0 && hrdata[31:16] == 16'h0000)
    else $error("reserved setup bits read nonzero");

  a_low_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    s_rd_addr(ACC_IDX_CH1_OCAL_LO) |=> hrdata[7:0] == 8'h00)
    else $error("reserved low byte read nonzero");

  a_filter_bypass: assert property (@(posedge hclk) disable iff (!hresetn)
    s_wr_data(ACC_E_CH2_SETUP) ##0 hwdata[2] |=> !ch2_dc_filter_active)
    else $error("bypass did not stop the dc filter");

  a_input_short: assert property (@(posedge hclk) disable iff (!hresetn)
    s_wr_data(ACC_E_CH2_SETUP) ##0 hwdata[1:0] == 2'h1 |=>
      ch2_sel_short && !ch2_sel_pins && !ch2_sel_test_pos && !ch2_sel_test_neg)
    else $error("shorted input not selected");

  // ************************************************************
  // Field, reserved bit and datapath checks
  // ************************************************************
  a_ofs1_low_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    s_wr_data(ACC_E_CH1_OCAL_LO) |=>
      ch1_offset_low_bits == $past(hwdata[15:8]))
    else $error("ch1 offset low byte not taken from bits 15:8");

  a_gain2_high_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    s_wr_data(ACC_E_CH2_GCAL_HI) |=>
      ch2_gain_high_bits == $past(hwdata[15:0]))
    else $error("ch2 gain high word not stored");

  a_delay_field: assert property (@(posedge hclk) disable iff (!hresetn)
    s_wr_data(ACC_E_CH2_SETUP) |=>
      ch2_sample_delay == $past(hwdata[15:6]))
    else $error("delay field not taken from bits 15:6");

  a_filter_governed: assert property (@(posedge hclk) disable iff (!hresetn)
    s_wr_data(ACC_E_CH2_SETUP) ##0 !hwdata[2] |=>
      ch2_dc_filter_active == (|global_dc_filter_setting))
    else $error("global setting did not govern the dc filter");

  a_input_route: assert property (@(posedge hclk) disable iff (!hresetn)
    s_wr_data(ACC_E_CH2_SETUP) |=> {ch2_sel_test_neg, ch2_sel_test_pos, ch2_sel_short,
      ch2_sel_pins} == 4'h1 << $past(hwdata[1:0]))
    else $error("input route does not follow select code");

  a_setup_resv: assert property (@(posedge hclk) disable iff (!hresetn)
    s_wr_data(ACC_E_CH2_SETUP) |=>
      reg_q[ACC_E_CH2_SETUP][5:3] == 3'h0)
    else $error("reserved setup bits took a write");

  a_low_resv: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q |=> reg_q[ACC_E_CH1_OCAL_LO][7:0] == 8'h00 &&
      reg_q[ACC_E_CH1_GCAL_LO][7:0] == 8'h00 && reg_q[ACC_E_CH2_OCAL_LO][7:0] == 8'h00)
    else $error("reserved low byte took a write");

  a_rdata_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    !(addr_take && !hwrite) |=>
      hrdata == 32'h0000_0000)
    else $error("read data outside a read data phase");

  a_unmapped_read: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_take && !hwrite && !addr_hit |=>
      hrdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  a_reg_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_pend_q |=>
      $stable(reg_q))
    else $error("register changed without a write");

  a_gain_sat: assert property (@(posedge hclk) disable iff (!hresetn)
    ch1_sample_valid && ch1_sample[23:21] == 3'h3 && ch1_gain[23:22] == 2'h3 |=>
      ch1_corrected == 24'h7F_FFFF)
    else $error("gain product above full scale did not clip");

  a_gain_half: assert property (@(posedge hclk) disable iff (!hresetn)
    ch1_sample_valid && ch1_gain == 24'h40_0000 |=>
      ch1_corrected == {$past(ch1_sample[23]), $past(ch1_sample[23:1])})
    else $error("half gain did not halve the sample");

  a_valid_delay: assert property (@(posedge hclk) disable iff (!hresetn)
    ch1_corrected_valid ==
      $past(ch1_sample_valid))
    else $error("corrected valid not one cycle after sample valid");

endmodule

// [src/acc_pkg.sv]
// Constants and types shared by the channel calibration register bank
package acc_pkg;

  // ************************************************************
  // Register map, word indices (byte address is four times)
  // ************************************************************
  localparam int unsigned ACC_NREG = 7;
  localparam logic [5:0] ACC_IDX_CH1_OCAL_LO = 6'h10;
  localparam logic [5:0] ACC_IDX_CH1_GCAL_HI = 6'h11;
  localparam logic [5:0] ACC_IDX_CH1_GCAL_LO = 6'h12;
  localparam logic [5:0] ACC_IDX_CH2_SETUP   = 6'h13;
  localparam logic [5:0] ACC_IDX_CH2_OCAL_HI = 6'h14;
  localparam logic [5:0] ACC_IDX_CH2_OCAL_LO = 6'h15;
  localparam logic [5:0] ACC_IDX_CH2_GCAL_HI = 6'h16;
  localparam logic [5:0] ACC_IDX_FIRST       = ACC_IDX_CH1_OCAL_LO;
  localparam logic [5:0] ACC_IDX_LAST        = ACC_IDX_CH2_GCAL_HI;

  // Entry numbers inside the storage array
  localparam logic [2:0] ACC_E_CH1_OCAL_LO = 3'h0;
  localparam logic [2:0] ACC_E_CH1_GCAL_HI = 3'h1;
  localparam logic [2:0] ACC_E_CH1_GCAL_LO = 3'h2;
  localparam logic [2:0] ACC_E_CH2_SETUP   = 3'h3;
  localparam logic [2:0] ACC_E_CH2_OCAL_HI = 3'h4;
  localparam logic [2:0] ACC_E_CH2_OCAL_LO = 3'h5;
  localparam logic [2:0] ACC_E_CH2_GCAL_HI = 3'h6;

  // ************************************************************
  // Reset values and writable bit masks, entry 6 first
  // ************************************************************
  localparam logic [ACC_NREG-1:0][15:0] ACC_RST_VAL = {
    16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
  localparam logic [ACC_NREG-1:0][15:0] ACC_WR_MASK = {
    16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFFC7, 16'hFF00, 16'hFFFF, 16'hFF00};

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned ACC_LO_FIELD_MSB = 15;
  localparam int unsigned ACC_LO_FIELD_LSB = 8;
  localparam int unsigned ACC_DLY_MSB      = 15;
  localparam int unsigned ACC_DLY_LSB      = 6;
  localparam int unsigned ACC_BYP_BIT      = 2;
  localparam int unsigned ACC_SEL_MSB      = 1;
  localparam int unsigned ACC_SEL_LSB      = 0;

  // ************************************************************
  // Input routing codes, sample delay and gain format
  // ************************************************************
  typedef enum logic [1:0] {
    ACC_SEL_PINS     = 2'h0,
    ACC_SEL_SHORT    = 2'h1,
    ACC_SEL_TEST_POS = 2'h2,
    ACC_SEL_TEST_NEG = 2'h3
  } acc_sel_e;

  localparam logic [10:0] ACC_DLY_BIAS   = 11'h200;
  localparam logic [23:0] ACC_GAIN_UNITY = 24'h80_0000;
  localparam int unsigned ACC_GAIN_FRAC  = 23;

  typedef enum logic [1:0] {
    ACC_DLY_IDLE = 2'b00,
    ACC_DLY_WAIT = 2'b01,
    ACC_DLY_FIRE = 2'b11
  } acc_dly_e;

  localparam logic [1:0] ACC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] ACC_HTRANS_SEQ    = 2'h3;

endpackage

// [src/acc_gain_apply.sv]
// Unsigned fixed-point gain applied to a signed sample, with saturation
`timescale 1ns/10ps
module acc_gain_apply
  import acc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [23:0] gain,
  input  wire logic [23:0] sample_in,
  input  wire logic        sample_in_valid,
  output logic      [23:0] sample_out,
  output logic             sample_out_valid
);

  logic signed [48:0] prod;
  logic signed [25:0] scaled;
  logic        [23:0] out_d;
  logic        [23:0] out_q;
  logic               vld_q;

  // ************************************************************
  // Multiply and saturate
  // ************************************************************
  always_comb begin
    prod   = $signed({sample_in[23], sample_in}) * $signed({1'b0, gain});
    scaled = prod[ACC_GAIN_FRAC+25:ACC_GAIN_FRAC];
    // Gain up to two can push past full scale, so clip
    if (scaled > 26'sh07F_FFFF) begin
      out_d = 24'h7F_FFFF;
    end else if (scaled < -26'sh080_0000) begin
      out_d = 24'h80_0000;
    end else begin
      out_d = scaled[23:0];
    end
    if (!sample_in_valid) begin
      out_d = out_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_q <= 24'h00_0000;
      vld_q <= 1'b0;
    end else begin
      out_q <= out_d;
      vld_q <= sample_in_valid;
    end
  end

  assign sample_out       = out_q;
  assign sample_out_valid = vld_q;

  a_gain_unity: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_in_valid && gain == ACC_GAIN_UNITY |=> sample_out == $past(sample_in))
    else $error("unity gain did not pass sample through");

endmodule

// [src/acc_sample_delay.sv]
// Conversion start delayed by a signed count of modulator clock ticks
`timescale 1ns/10ps
module acc_sample_delay
  import acc_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [9:0] delay,
  input  wire logic       start,
  input  wire logic       mod_tick,
  output logic            convert
);

  acc_dly_e    state_q;
  acc_dly_e    state_d;
  logic [10:0] cnt_q;
  logic [10:0] cnt_d;

  // ************************************************************
  // Delay sequencer
  // ************************************************************
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ACC_DLY_IDLE: begin
        if (start) begin
          // Bias lets negative counts lead the nominal instant
          cnt_d   = ACC_DLY_BIAS + {delay[9], delay};
          state_d = ACC_DLY_WAIT;
        end
      end
      ACC_DLY_WAIT: begin
        if (cnt_q == 11'h000) begin
          state_d = ACC_DLY_FIRE;
        end else if (mod_tick) begin
          cnt_d = cnt_q - 11'h001;
        end
      end
      ACC_DLY_FIRE: begin
        state_d = ACC_DLY_IDLE;
      end
      default: begin
        state_d = ACC_DLY_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ACC_DLY_IDLE;
      cnt_q   <= 11'h000;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign convert = (state_q == ACC_DLY_FIRE);

  a_fire_cause: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(convert) |-> $past(state_q == ACC_DLY_WAIT && cnt_q == 11'h000))
    else $error("convert without delay expiry");

  a_fire_single: assert property (@(posedge hclk) disable iff (!hresetn)
    convert |=> !convert)
    else $error("convert longer than one cycle");

endmodule

// [verification/acc_regs_top_bench.sv]
// Self-checking testbench for the channel calibration register bank
`timescale 1ns/10ps
module acc_regs_top_bench;
  import acc_pkg::*;

  // ************************************************************
  // Clock, reset and design ports
  // ************************************************************
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic        hready;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  global_dc = 4'h0;
  logic        conv_start = 1'b0;
  logic        mod_tick = 1'b0;
  logic [23:0] ch1_sample = 24'h00_0000;
  logic        ch1_sample_valid = 1'b0;
  logic [7:0]  o1_lo, g1_lo, o2_lo;
  logic [15:0] g1_hi, o2_hi, g2_hi;
  logic [23:0] ch1_gain, ch1_corr, ch2_offset;
  logic        ch1_corr_valid, byp, dc_act, s_pin, s_sh, s_pos, s_neg, ch2_convert;
  logic [9:0]  dly;
  logic [1:0]  sel;
  int          failures = 0;
  int          num_checks = 0;
  logic [31:0] rd;
  int          cnt;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #5 hclk = ~hclk;

  acc_regs_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .global_dc_filter_setting(global_dc),
    .conv_start(conv_start), .mod_tick(mod_tick), .ch1_sample(ch1_sample),
    .ch1_sample_valid(ch1_sample_valid), .ch1_offset_low_bits(o1_lo),
    .ch1_gain_high_bits(g1_hi), .ch1_gain_low_bits(g1_lo), .ch1_gain(ch1_gain),
    .ch1_corrected(ch1_corr), .ch1_corrected_valid(ch1_corr_valid),
    .ch2_sample_delay(dly), .ch2_dc_filter_bypass(byp), .ch2_dc_filter_active(dc_act),
    .ch2_input_select(sel), .ch2_sel_pins(s_pin), .ch2_sel_short(s_sh),
    .ch2_sel_test_pos(s_pos), .ch2_sel_test_neg(s_neg), .ch2_offset_high_bits(o2_hi),
    .ch2_offset_low_bits(o2_lo), .ch2_offset(ch2_offset), .ch2_gain_high_bits(g2_hi),
    .ch2_convert(ch2_convert));

  // ************************************************************
  // Expected contents, our own copy of the map
  // ************************************************************
  logic [15:0] rst_tab [7] = '{16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000,
                               16'h0000, 16'h8000};
  logic [15:0] msk_tab [7] = '{16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFC7, 16'hFFFF,
                               16'hFF00, 16'hFFFF};

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(logic [31:0] seen, logic [31:0] exp, string what);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Bounded wait for ready; every call starts right after a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
      if (n > 20) begin
        failures++;
        $display("unexpected at %0t: bus never ready", $time);
        end_of_test();
      end
    end while (hreadyout !== 1'b1);
  endtask

  task automatic bus(logic wr, logic [31:0] addr, logic [31:0] wdat, output logic [31:0] rdat);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= ACC_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wr ? wdat : 32'h0000_0000;
    wait_ready();
    rdat = hrdata;
    check({31'h0, hresp}, 32'h0000_0000, "response");
  endtask

  task automatic wr32(logic [31:0] addr, logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, addr, d, dummy);
  endtask

  task automatic rd32(logic [31:0] addr, output logic [31:0] d);
    bus(1'b0, addr, 32'h0000_0000, d);
  endtask

  // Saturating signed sample times unsigned gain with 23 fraction bits
  function automatic logic [23:0] gain_exp(logic [23:0] s, logic [23:0] g);
    logic signed [48:0] p;
    p = ($signed({{25{s[23]}}, s}) * $signed({25'h0, g})) >>> 23;
    if (p > $signed(49'h7F_FFFF))
      return 24'h7F_FFFF;
    if (p < -$signed(49'h80_0000))
      return 24'h80_0000;
    return p[23:0];
  endfunction

  // ************************************************************
  // Tests
  // ************************************************************
  logic [23:0] gtab [3] = '{24'h80_0000, 24'h40_0000, 24'hFF_FF00};
  logic [23:0] stab [3] = '{24'h10_0000, 24'hF0_0000, 24'h60_0000};

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 7; i++) begin
      rd32(32'h40 + 4 * i, rd);
      check(rd, {16'h0, rst_tab[i]}, "reset value");
    end
    check({8'h0, ch1_gain}, 32'h0080_0000, "unity gain at reset");
    check({28'h0, s_pin, s_sh, s_pos, s_neg}, 32'h0000_0008, "pins at reset");
    $display("test reset_values done");

    // Reserved bits stay zero; a register that never updates shows up on the all-ones pass
    for (int i = 0; i < 7; i++) begin
      wr32(32'h40 + 4 * i, 32'hFFFF_FFFF);
      rd32(32'h40 + 4 * i, rd);
      check(rd, {16'h0, msk_tab[i]}, "all ones readback");
      wr32(32'h40 + 4 * i, 32'h0000_0000);
      rd32(32'h40 + 4 * i, rd);
      check(rd, 32'h0000_0000, "zero readback");
    end
    wr32(32'h0000_005C, 32'hFFFF_FFFF);
    rd32(32'h0000_005C, rd);
    check(rd, 32'h0000_0000, "unmapped read");
    $display("test access_kinds done");

    // Splitting of 24-bit values across high and low words
    wr32(32'h50, 32'h0000_8123);
    wr32(32'h54, 32'h0000_45A5);
    wr32(32'h44, 32'h0000_9ABC);
    wr32(32'h48, 32'h0000_DE77);
    wr32(32'h40, 32'h0000_3C11);
    wr32(32'h58, 32'h0000_7E01);
    @(posedge hclk);
    check({8'h0, ch2_offset}, 32'h0081_2345, "ch2 offset word");
    check({16'h0, o2_hi}, 32'h0000_8123, "ch2 offset high");
    check({24'h0, o2_lo}, 32'h0000_0045, "ch2 offset low");
    check({24'h0, o1_lo}, 32'h0000_003C, "ch1 offset low");
    check({8'h0, ch1_gain}, 32'h009A_BCDE, "ch1 gain word");
    check({16'h0, g1_hi}, 32'h0000_9ABC, "ch1 gain high");
    check({24'h0, g1_lo}, 32'h0000_00DE, "ch1 gain low");
    check({16'h0, g2_hi}, 32'h0000_7E01, "ch2 gain high");
    $display("test field_mapping done");

    // Gain stage: unity, half, near two with saturation
    for (int i = 0; i < 3; i++) begin
      wr32(32'h44, {16'h0, gtab[i][23:8]});
      wr32(32'h48, {16'h0, gtab[i][7:0], 8'h00});
      ch1_sample <= stab[i];
      ch1_sample_valid <= 1'b1;
      cnt = 0;
      do begin
        @(posedge hclk);
        cnt++;
        ch1_sample_valid <= 1'b0;
      end while (ch1_corr_valid !== 1'b1 && cnt < 20);
      check(cnt, 2, "gain latency");
      check({8'h0, ch1_corr}, {8'h0, gain_exp(stab[i], gtab[i])}, "gain result");
    end
    $display("test gain_stage done");

    // Every input route, bypass on and off, global setting off and on
    for (int c = 0; c < 8; c++) begin
      global_dc <= c[0] ? 4'h3 : 4'h0;
      wr32(32'h4C, {16'h0, 10'h2A5, 3'b000, c[2], c[1:0]});
      @(posedge hclk);
      check({30'h0, sel}, {30'h0, c[1:0]}, "input select");
      check({28'h0, s_pin, s_sh, s_pos, s_neg}, 32'h8 >> c[1:0], "route decode");
      check({31'h0, byp}, {31'h0, c[2]}, "bypass bit");
      check({31'h0, dc_act}, {31'h0, ~c[2] & c[0]}, "filter active");
      check({22'h0, dly}, 32'h0000_02A5, "delay field");
    end
    $display("test setup_fields done");

    // Most negative delay gives zero ticks; four ticks more adds four cycles
    mod_tick <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr32(32'h4C, {16'h0, 10'h200 + 10'(4 * k), 6'h00});
      conv_start <= 1'b1;
      cnt = 0;
      do begin
        @(posedge hclk);
        cnt++;
        conv_start <= 1'b0;
      end while (ch2_convert !== 1'b1 && cnt < 40);
      check(cnt, 3 + 4 * k, "convert delay");
      @(posedge hclk);
      check({31'h0, ch2_convert}, 32'h0000_0000, "convert one cycle");
    end
    mod_tick <= 1'b0;
    $display("test sample_delay done");

    // Reset in mid-run brings the whole map back to its reset values
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 7; i++) begin
      rd32(32'h40 + 4 * i, rd);
      check(rd, {16'h0, rst_tab[i]}, "value after reset");
    end
    check({8'h0, ch1_gain}, 32'h0080_0000, "unity gain after reset");
    $display("test mid_reset done");
    end_of_test();
  end

  initial begin
    #900000;
    failures++;
    $display("unexpected at %0t: run too long", $time);
    end_of_test();
  end
endmodule
